/* File: rb_pkg.sv */
package rb_pkg;
   // APB register offsets.
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] START_OFF = 8'h08;
   localparam logic [7:0] CFGWIN_OFF = 8'h0C;
   // Control register fields.
   localparam int LIMIT_LSB = 0;
   localparam int CONFIGURED_BIT = 2;
   localparam int HOSTPORT_BIT = 3;
   localparam int GOD_SRC_LSB = 4;
   localparam int GOD_INV_BIT = 6;
   localparam int CAPMODE_LSB = 7;
   localparam int TDO_USE_BIT = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Readback limit settings.
   localparam logic [1:0] LIMIT_NONE = 2'h0;
   localparam logic [1:0] LIMIT_ONE = 2'h1;
   localparam logic [1:0] LIMIT_UNL = 2'h2;
   // Output disable source.
   localparam logic [1:0] GOD_OFF = 2'h0;
   localparam logic [1:0] GOD_PAD = 2'h1;
   localparam logic [1:0] GOD_INT = 2'h2;
   // Capture modes.
   localparam logic [1:0] CAP_NONE = 2'h0;
   localparam logic [1:0] CAP_ENTRY = 2'h1;
   localparam logic [1:0] CAP_SIG = 2'h2;
   localparam logic [1:0] CAP_BOTH = 2'h3;
   // Timing in config clock cycles, and the frame start pair.
   localparam int START_DELAY = 3;
   localparam int RESTART_EDGES = 2;
   localparam logic [1:0] FRAME_START = 2'h1;
endpackage

/* File: rb_frame_mem.sv */
`timescale 1ns/1ns
// Frame store: one word per frame, registered read, writable by capture.
module rb_frame_mem #(
   parameter int AW = 4,
   parameter int DW = 16
) (
   // Clock.
   input wire logic pclk,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port.
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // rb_frame_mem

/* File: rb_core.sv */
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
// Function
// - Limit readbacks to none, one, unlimited.
// - Host processor port disables pin readback.
// - Falling request edge begins readback.
// - High plus two clock rises restarts at the start register frame.
// - One bit out per config clock rise.
// - Each frame opens with 01 pair.
// - Frames read at consecutive addresses.
// - Data may route to alternate pin.
// - Unconfigured: request drives disable, no readback.
// - Configured: disable source off, pad, internal.
// - Disable active low, invertible when configured.
// - Disable tristates outputs, pulls inputs up.
// - Disable tristates shared serial output.
// - Control inputs stay live with pull-ups.
// - Disable tristates done, pulls input up.
// - Capture none, on entry, signal, either.
// - Capture signal low writes continuously.
// - Frames exclude header; match configuration data.
// - Readback during operation, never daisy-chained.
module rb_core #(
   parameter int AW = 4,
   parameter int DW = 16,
   parameter int NIO = 8
) (
   // APB.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Readback pins.
   input wire logic config_clock,
   input wire logic rd_request_pin,
   output logic rd_data_o,
   output logic rd_data_oe_n,
   output logic rd_data_alt,
   input wire logic tdo_data,
   // Internal signals.
   input wire logic int_disable_src,
   input wire logic capture_sig,
   input wire logic [DW-1:0] live_state,
   // Pad control.
   output logic global_output_disable,
   output logic user_out_hiz,
   output logic user_pullup,
   output logic user_pulldown_en,
   output logic ctl_pullup,
   output logic done_hiz,
   output logic done_pullup
);
   // ****************************************
   // State.
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_SHIFT = 2'b10,
      ST_DONE = 2'b11
   } rb_state_e;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [AW-1:0] start;
      logic [AW-1:0] addr;
      logic [DW+1:0] shreg;
      logic [5:0] bitcnt;
      logic [1:0] cnt;
      logic [1:0] used;
      logic [2:0] clk_s;
      logic [2:0] req_s;
      logic dout;
      rb_state_e st;
      logic [31:0] rdat;
   } state_s;

   state_s s_r, s_nxt;

   logic clk_rise, req_low, rb_start, configured, host_port;
   logic rb_allowed, god_raw, god;
   logic [1:0] limit, god_src, capmode;
   logic [DW-1:0] mem_rdata;
   logic cap_we;
   logic [AW-1:0] cap_addr;
   logic acc;

   assign clk_rise = s_r.clk_s[1] & ~s_r.clk_s[2];
   assign req_low = ~s_r.req_s[1];
   // A readback starts at a link clock rise once the idle counter has seen the re-arm rises.
   assign rb_start = clk_rise && s_r.st == ST_IDLE && req_low && rb_allowed &&
                     s_r.cnt >= 2'(rb_pkg::RESTART_EDGES);
   assign configured = s_r.ctrl[rb_pkg::CONFIGURED_BIT];
   assign host_port = s_r.ctrl[rb_pkg::HOSTPORT_BIT];
   assign limit = s_r.ctrl[rb_pkg::LIMIT_LSB +: 2];
   assign god_src = s_r.ctrl[rb_pkg::GOD_SRC_LSB +: 2];
   assign capmode = s_r.ctrl[rb_pkg::CAPMODE_LSB +: 2];

   // ****************************************
   // Global output disable.
   // ****************************************
   always_comb begin
      if (!configured) begin
         god_raw = ~s_r.req_s[1];
      end else begin
         case (god_src)
            rb_pkg::GOD_PAD: god_raw = ~s_r.req_s[1];
            rb_pkg::GOD_INT: god_raw = ~int_disable_src;
            default: god_raw = 1'b0;
         endcase
      end
   end
   assign god = (configured && (god_src == rb_pkg::GOD_PAD || god_src == rb_pkg::GOD_INT) &&
                 s_r.ctrl[rb_pkg::GOD_INV_BIT]) ? ~god_raw : god_raw;
   assign global_output_disable = god;
   assign user_out_hiz = god;
   assign user_pullup = god;
   assign user_pulldown_en = ~god;
   assign ctl_pullup = 1'b1;
   assign done_hiz = god;
   assign done_pullup = god;

   // Pad used for readback only when configured and not claimed for disable.
   assign rb_allowed = configured && !host_port && god_src != rb_pkg::GOD_PAD &&
                       limit != rb_pkg::LIMIT_NONE &&
                       !(limit == rb_pkg::LIMIT_ONE && s_r.used != 2'h0);

   // ****************************************
   // Serial output routing.
   // ****************************************
   always_comb begin
      if (s_r.ctrl[rb_pkg::TDO_USE_BIT]) begin
         rd_data_o = tdo_data;
         rd_data_alt = s_r.dout;
      end else begin
         rd_data_o = s_r.dout;
         rd_data_alt = 1'b0;
      end
   end
   assign rd_data_oe_n = god;

   // ****************************************
   // Frame store and capture.
   // ****************************************
   always_comb begin
      cap_we = 1'b0;
      cap_addr = s_r.addr;
      if (capmode == rb_pkg::CAP_SIG || capmode == rb_pkg::CAP_BOTH) begin
         if (!capture_sig) begin
            cap_we = 1'b1;
         end
      end
      if ((capmode == rb_pkg::CAP_ENTRY || capmode == rb_pkg::CAP_BOTH) && rb_start) begin
         cap_we = 1'b1;
         cap_addr = s_r.start;
      end
   end

   rb_frame_mem #(.AW(AW), .DW(DW)) u_mem (
      .pclk(pclk),
      .we(cap_we),
      .waddr(cap_addr),
      .wdata(live_state),
      .raddr(s_r.addr),
      .rdata(mem_rdata)
   );

   // ****************************************
   // APB and readback sequencer.
   // ****************************************
   assign pready = 1'b1;
   assign acc = psel & penable;
   always_comb begin
      pslverr = 1'b0;
      if (paddr != rb_pkg::CTRL_OFF && paddr != rb_pkg::STAT_OFF &&
          paddr != rb_pkg::START_OFF) begin
         pslverr = acc;
      end
   end
   assign prdata = s_r.rdat;

   always_comb begin
      s_nxt = s_r;
      s_nxt.clk_s = {s_r.clk_s[1:0], config_clock};
      s_nxt.req_s = {s_r.req_s[1:0], rd_request_pin};
      if (psel && !penable) begin
         case (paddr)
            rb_pkg::CTRL_OFF: s_nxt.rdat = s_r.ctrl;
            rb_pkg::STAT_OFF: begin
               s_nxt.rdat = 32'h0000_0000;
               s_nxt.rdat[1:0] = s_r.st;
               s_nxt.rdat[8 +: AW] = s_r.addr;
               s_nxt.rdat[17:16] = s_r.used;
            end
            rb_pkg::START_OFF: s_nxt.rdat = {{(32-AW){1'b0}}, s_r.start};
            default: s_nxt.rdat = 32'h0000_0000;
         endcase
      end
      if (acc && pwrite) begin
         if (paddr == rb_pkg::CTRL_OFF) begin
            s_nxt.ctrl = pwdata;
         end
         if (paddr == rb_pkg::START_OFF) begin
            s_nxt.start = pwdata[AW-1:0];
         end
      end
      if (clk_rise) begin
         case (s_r.st)
            ST_IDLE: begin
               if (rb_start) begin
                  s_nxt.st = ST_WAIT;
                  s_nxt.addr = s_r.start;
                  s_nxt.cnt = 2'h0;
                  if (limit == rb_pkg::LIMIT_ONE) begin
                     s_nxt.used = 2'h1;
                  end
               end else if (!req_low && s_r.cnt != 2'h3) begin
                  s_nxt.cnt = s_r.cnt + 2'h1;
               end
            end
            ST_WAIT: begin
               s_nxt.cnt = s_r.cnt + 2'h1;
               if (s_r.cnt == 2'(rb_pkg::START_DELAY - 1)) begin
                  s_nxt.shreg = {rb_pkg::FRAME_START, mem_rdata};
                  s_nxt.bitcnt = 6'h0;
                  s_nxt.st = ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               s_nxt.dout = s_r.shreg[DW+1];
               s_nxt.shreg = {s_r.shreg[DW:0], 1'b0};
               s_nxt.bitcnt = s_r.bitcnt + 6'h1;
               // The last frame bit leaves at count DW+1; only then does the address move on.
               if (s_r.bitcnt == 6'(DW + 1)) begin
                  s_nxt.addr = s_r.addr + 1'b1;
                  s_nxt.cnt = 2'(rb_pkg::START_DELAY - 1);
                  s_nxt.st = ST_WAIT;
               end
            end
            default: s_nxt.st = ST_IDLE;
         endcase
         if (!req_low && s_r.st != ST_IDLE) begin
            s_nxt.st = ST_IDLE;
            s_nxt.cnt = 2'h1;
            s_nxt.dout = 1'b0;
         end
      end
      if (!configured || host_port) begin
         s_nxt.st = ST_IDLE;
         s_nxt.used = 2'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{ctrl: rb_pkg::CTRL_RESET, st: ST_IDLE, req_s: 3'b111, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Checks.
   // ****************************************
   property p_disable_unconf;
      @(posedge pclk) disable iff (!presetn)
         !configured |-> (global_output_disable == ~s_r.req_s[1]);
   endproperty
   a_disable_unconf: assert property (p_disable_unconf)
      else $error("disable not following request pad");

   property p_no_rb_unconf;
      @(posedge pclk) disable iff (!presetn)
         !configured |=> s_r.st == ST_IDLE;
   endproperty
   a_no_rb_unconf: assert property (p_no_rb_unconf)
      else $error("readback active while unconfigured");

   property p_host_port;
      @(posedge pclk) disable iff (!presetn)
         host_port |=> s_r.st == ST_IDLE;
   endproperty
   a_host_port: assert property (p_host_port)
      else $error("readback active with host port");

   property p_tristate;
      @(posedge pclk) disable iff (!presetn)
         god |-> rd_data_oe_n && done_hiz && user_out_hiz && !user_pulldown_en;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("pads driven while disabled");

   property p_shift_on_rise;
      @(posedge pclk) disable iff (!presetn)
         (s_r.st == ST_SHIFT && clk_rise && req_low) |=> s_r.dout == $past(s_r.shreg[DW+1]);
   endproperty
   a_shift_on_rise: assert property (p_shift_on_rise)
      else $error("bit not shifted on clock rise");

   property p_addr_inc;
      @(posedge pclk) disable iff (!presetn)
         (s_r.st == ST_SHIFT && clk_rise && req_low && s_r.bitcnt == 6'(DW + 1) && configured &&
          !host_port) |=> s_r.addr == $past(s_r.addr) + 1'b1;
   endproperty
   a_addr_inc: assert property (p_addr_inc)
      else $error("frame address not advanced");

   property p_start_pair;
      @(posedge pclk) disable iff (!presetn)
         ($rose(s_r.st == ST_SHIFT)) |-> s_r.shreg[DW+1 -: 2] == rb_pkg::FRAME_START;
   endproperty
   a_start_pair: assert property (p_start_pair)
      else $error("frame lacks start pair");

   property p_limit_none;
      @(posedge pclk) disable iff (!presetn)
         (limit == rb_pkg::LIMIT_NONE && s_r.st == ST_IDLE) |=> s_r.st == ST_IDLE;
   endproperty
   a_limit_none: assert property (p_limit_none)
      else $error("readback started while prohibited");

   property p_release_stop;
      @(posedge pclk) disable iff (!presetn)
         (clk_rise && !req_low && configured) |=> s_r.st == ST_IDLE;
   endproperty
   a_release_stop: assert property (p_release_stop)
      else $error("readback continued with request high");

   property p_cont_capture;
      @(posedge pclk) disable iff (!presetn)
         (capmode == rb_pkg::CAP_SIG && !capture_sig) |-> cap_we;
   endproperty
   a_cont_capture: assert property (p_cont_capture)
      else $error("continuous capture missing");
endmodule // rb_core

/* File: rb_reader.sv */
`timescale 1ns/1ns
// Behavioural reader: the link clock runs only while it restarts, hunts for or collects a frame.
module rb_reader #(
   parameter int DW = 16
) (
   // Link pins.
   output logic config_clock,
   output logic rd_request_pin,
   input wire logic rd_data_o
);
   initial begin
      config_clock = 1'b0;
      rd_request_pin = 1'b1;
   end
   // One link clock period of 160 ns; the bit is taken just before the rise.
   task automatic pulse(output logic b);
      #80;
      b = rd_data_o;
      config_clock = 1'b1;
      #80;
      config_clock = 1'b0;
   endtask
   task automatic restart();
      logic b;
      rd_request_pin = 1'b1;
      pulse(b);
      pulse(b);
      rd_request_pin = 1'b0;
   endtask
   task automatic set_pad(input logic lvl);
      rd_request_pin = lvl;
   endtask
   // Hunts for the start pair, then shifts in one frame MSB first.
   task automatic get_frame(output logic found, output logic [DW-1:0] d);
      logic prev;
      logic b;
      found = 1'b0;
      prev = 1'b1;
      d = '0;
      for (int i = 0; i < 60 && !found; i++) begin
         pulse(b);
         found = (prev === 1'b0) && (b === 1'b1);
         prev = b;
      end
      for (int i = 0; i < DW && found; i++) begin
         pulse(b);
         d = {d[DW-2:0], b};
      end
   endtask
endmodule // rb_reader

/* File: config_readback_and_global_tristate_tb.sv */
`timescale 1ns/1ns
module config_readback_and_global_tristate_tb;
   localparam int AW = 4;
   localparam int DW = 16;
   localparam logic [DW-1:0] USED_MASK = 16'hFFFF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, found;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, ctrl, r;
   logic config_clock, rd_request_pin, rd_data_o, rd_data_oe_n, rd_data_alt, tdo_data;
   logic int_disable_src, capture_sig, global_output_disable, user_out_hiz, user_pullup;
   logic user_pulldown_en, ctl_pullup, done_hiz, done_pullup, rd_line;
   logic [DW-1:0] live_state, frame;
   int seed, bad_count, checked, s;

   rb_core #(.AW(AW), .DW(DW), .NIO(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .config_clock(config_clock),
      .rd_request_pin(rd_request_pin), .rd_data_o(rd_data_o), .rd_data_oe_n(rd_data_oe_n),
      .rd_data_alt(rd_data_alt), .tdo_data(tdo_data), .int_disable_src(int_disable_src),
      .capture_sig(capture_sig), .live_state(live_state),
      .global_output_disable(global_output_disable), .user_out_hiz(user_out_hiz),
      .user_pullup(user_pullup), .user_pulldown_en(user_pulldown_en),
      .ctl_pullup(ctl_pullup), .done_hiz(done_hiz), .done_pullup(done_pullup));
   rb_reader #(.DW(DW)) rdr (.config_clock(config_clock), .rd_request_pin(rd_request_pin),
      .rd_data_o(rd_line));
   // The reader listens on the alternate pin whenever the shared pad carries scan data.
   assign rd_line = ctrl[rb_pkg::TDO_USE_BIT] ? rd_data_alt : rd_data_o;

   always #5 pclk = ~pclk;

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(1'b0, "apb no ready");
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic god_exp(logic [31:0] c, logic pad, logic isrc);
      if (!c[rb_pkg::CONFIGURED_BIT]) return ~pad;
      case (c[rb_pkg::GOD_SRC_LSB +: 2])
         rb_pkg::GOD_PAD: return ~pad ^ c[rb_pkg::GOD_INV_BIT];
         rb_pkg::GOD_INT: return ~isrc ^ c[rb_pkg::GOD_INV_BIT];
         default: return 1'b0;
      endcase
   endfunction
   task automatic pins();
      logic e;
      repeat (6) @(posedge pclk);
      e = god_exp(ctrl, rd_request_pin, int_disable_src);
      chk(global_output_disable === e, "disable level");
      chk({user_out_hiz, user_pullup, user_pulldown_en, rd_data_oe_n} === {e, e, ~e, e},
         "user pads");
      chk({ctl_pullup, done_hiz, done_pullup} === {1'b1, e, e}, "control pads");
      chk(rd_data_alt === 1'b0, "alternate pin idle");
   endtask
   task automatic setc(input logic [31:0] c);
      ctrl = c;
      apb(1'b1, rb_pkg::CTRL_OFF, c);
   endtask
   task automatic try_rb(input logic exp, input string msg);
      rdr.restart();
      rdr.get_frame(found, frame);
      chk(found === exp, msg);
   endtask

   // ********************************
   // Main sequence.
   // ********************************
   initial begin
      seed = 32'h2431;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, tdo_data, capture_sig, int_disable_src} = 6'h03;
      paddr = '0;
      pwdata = '0;
      live_state = '0;
      ctrl = '0;
      bad_count = 0;
      checked = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, rb_pkg::CTRL_OFF, '0);
      chk(rd === rb_pkg::CTRL_RESET, "ctrl reset value");
      apb(1'b0, 8'h10, '0);
      chk(err === 1'b1, "unmapped address accepted");
      for (int i = 0; i < 4; i++) begin
         rdr.set_pad(i[0]);
         pins();
      end
      try_rb(1'b0, "readback while unconfigured");
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         int_disable_src <= r[0];
         setc(32'h4 | ((i % 3) << rb_pkg::GOD_SRC_LSB) | ((i / 3) << rb_pkg::GOD_INV_BIT));
         rdr.set_pad(r[1]);
         pins();
      end
      setc(32'h4 | rb_pkg::LIMIT_ONE);
      try_rb(1'b1, "first of one readback");
      try_rb(1'b0, "second of one readback");
      setc(32'h4 | rb_pkg::LIMIT_NONE);
      try_rb(1'b0, "readback prohibited");
      setc(32'hC | rb_pkg::LIMIT_UNL);
      try_rb(1'b0, "readback with host port");
      // Continuous capture fills every frame, then frames are read from a random start.
      r = $random(seed);
      s = int'(r[19:16]) % 14;
      live_state <= r[DW-1:0];
      capture_sig <= 1'b0;
      setc(32'h4 | rb_pkg::LIMIT_UNL | (rb_pkg::CAP_SIG << rb_pkg::CAPMODE_LSB));
      apb(1'b1, rb_pkg::START_OFF, 32'(s));
      rdr.restart();
      for (int i = 0; i < 16; i++) rdr.get_frame(found, frame);
      rdr.restart();
      for (int i = 0; i < 2; i++) begin
         rdr.get_frame(found, frame);
         chk(found === 1'b1 && ((frame ^ r[DW-1:0]) & USED_MASK) === '0, "frame data");
      end
      apb(1'b0, rb_pkg::STAT_OFF, '0);
      chk(rd[8 +: AW] === 4'(s + 2), "address after two frames");
      try_rb(1'b1, "restart readback");
      apb(1'b0, rb_pkg::STAT_OFF, '0);
      chk(rd[8 +: AW] === 4'(s + 1), "address after restart");
      // Entry capture (alone and with the signal path) stores the start frame.
      capture_sig <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         r = $random(seed);
         live_state <= r[DW-1:0];
         setc(32'h4 | rb_pkg::LIMIT_UNL |
            ((m == 0 ? rb_pkg::CAP_ENTRY : rb_pkg::CAP_BOTH) << rb_pkg::CAPMODE_LSB));
         try_rb(1'b1, "entry capture readback");
         chk(frame === r[DW-1:0], "entry capture data");
      end
      live_state <= ~r[DW-1:0];
      setc(32'h4 | rb_pkg::LIMIT_UNL);
      try_rb(1'b1, "readback without capture");
      chk(frame === r[DW-1:0], "stored data without capture");
      setc(32'h206);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         tdo_data <= r[0];
         repeat (3) @(posedge pclk);
         chk(rd_data_o === r[0], "scan data on shared pin");
      end
      try_rb(1'b1, "readback on alternate pin");
      conclude();
   end
endmodule // config_readback_and_global_tristate_tb
